// ### logic/pcgdu_regs.svh
`ifndef PCGDU_REGS_SVH
`define PCGDU_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PCGDU_PLL_CFG_OFF      8'h18
`define PCGDU_PERIPH_GATE_OFF  8'h1c
`define PCGDU_SYS_MODE_OFF     8'h20
`define PCGDU_MAIN_PRESC_OFF   8'h40
`define PCGDU_BUS_PRESC_OFF    8'h44
`define PCGDU_PERIPH_RST_OFF   8'h48
`define PCGDU_CLK_CTRL_OFF     8'h00

// ****************************************
// Reset values
// ****************************************
`define PCGDU_PLL_CFG_RST      8'h07
`define PCGDU_PERIPH_GATE_RST  17'h1ffff
`define PCGDU_SYS_MODE_RST     2'h1
`define PCGDU_CLK_CTRL_RST     2'h0

// ****************************************
// Field positions
// ****************************************
`define PCGDU_FREE_RUN_BIT     7
`define PCGDU_REF_BAND_BIT     6
`define PCGDU_MULT_LSB         4
`define PCGDU_DIV_MSB          2
`define PCGDU_PLL_CFG_MASK     8'hf7
`define PCGDU_GATE_EXTMEM_BIT  2
`define PCGDU_GATE_USB_BIT     4
`define PCGDU_SOFT_RST_BIT     1
`define PCGDU_IDLE_BIT         0
`define PCGDU_BUS2_LSB         8
`define PCGDU_EXTMEM_RST_BIT   2
`define PCGDU_PRST_MASK        4'hf
`define PCGDU_ALLOW_HALT_BIT   1
`define PCGDU_ALLOW_SRES_BIT   0
`define PCGDU_DIV_BYPASS       3'h7

`endif

// ### logic/pcgdu_pkg.sv
package pcgdu_pkg;
  typedef enum logic [1:0] {
    PCGDU_RUN,
    PCGDU_IDLE,
    PCGDU_SOFT_RESET
  } pcgdu_mode_t;

  typedef struct packed {
    logic [16:0] periph_clk_gate;
    logic [3:0]  prst;
    logic [1:0]  ctrl;
    logic [1:0]  main_clk_ratio;
  } pcgdu_misc_t;
endpackage

// ### logic/pcgdu_prescaler.sv
`timescale 1ns/1ps
// Glitch-free ratio divider: new ratio taken only at a period boundary
module pcgdu_prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] ratio_i,
  output logic            tick_o,
  output logic [1:0]      ratio_o
);
  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] ratio;
    logic       tick;
  } pcgdu_presc_t;

  pcgdu_presc_t st;
  pcgdu_presc_t next_st;
  logic [2:0]   last;

  always_comb begin
    next_st = st;
    last = 3'h0;
    case (st.ratio)
      2'h0:    last = 3'h0;
      2'h1:    last = 3'h1;
      2'h2:    last = 3'h3;
      default: last = 3'h7;
    endcase
    next_st.tick = (st.cnt == last);
    if (st.cnt == last) begin
      next_st.cnt   = 3'h0;
      next_st.ratio = ratio_i;
    end else begin
      next_st.cnt = st.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o  = st.tick;
  assign ratio_o = st.ratio;

  ratio_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.cnt != last) |=> $stable(st.ratio))
    else $error("prescaler ratio changed mid period");
endmodule

// ### logic/pcgdu_top.sv
`timescale 1ns/1ps
`include "pcgdu_regs.svh"
module pcgdu_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  input  wire logic        pll_lock_i,
  input  wire logic        regulator_good_i,
  input  wire logic        path_request_i,
  input  wire logic        irq_ack_i,
  output logic             pll_enable_o,
  output logic             pll_free_run_o,
  output logic             ref_input_band_o,
  output logic [4:0]       pll_multiplier_o,
  output logic [2:0]       pll_divisor_o,
  output logic             pll_path_select_o,
  output logic [16:0]      periph_clk_gate_o,
  output logic             extmem_clk_en_o,
  output logic             usb_clk_en_o,
  output logic             cpu_idle_o,
  output logic             soft_reset_o,
  output logic             main_clk_en_o,
  output logic             bus1_clk_en_o,
  output logic             bus2_clk_en_o,
  output logic             extmem_if_reset_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]        pll_cfg;
    logic [16:0]       gate;
    logic              idle_until_irq;
    logic              soft_req;
    logic [1:0]        allow;
    logic [1:0]        main_clk_ratio;
    logic [1:0]        bus1_clk_ratio;
    logic [1:0]        bus2_clk_ratio;
    logic [3:0]        prst;
    logic              extmem_rst;
    logic              path_sel;
    logic [4:0]        mult;
    logic              pll_en;
    logic [31:0]       rdata;
    pcgdu_pkg::pcgdu_mode_t mode;
  } pcgdu_state_t;

  pcgdu_state_t st;
  pcgdu_state_t next_st;
  logic         main_tick;
  logic         bus1_tick;
  logic         bus2_tick;
  logic [1:0]   main_eff;

  // Multiplier code decode, used by the multiplier output and the mult_map_a check
  function automatic logic [4:0] mult_of(input logic [1:0] code);
    case (code)
      2'h2:    mult_of = 5'd24;
      2'h0:    mult_of = 5'd20;
      2'h3:    mult_of = 5'd16;
      default: mult_of = 5'd12;
    endcase
  endfunction

  function automatic logic pll_bypassed(input logic [7:0] cfg);
    pll_bypassed = (cfg[`PCGDU_DIV_MSB:0] == `PCGDU_DIV_BYPASS);
  endfunction

  // ****************************************
  // Prescalers
  // ****************************************
  pcgdu_prescaler u_main (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (st.main_clk_ratio),
    .tick_o  (main_tick),
    .ratio_o (main_eff)
  );

  pcgdu_prescaler u_bus1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (st.bus1_clk_ratio),
    .tick_o  (bus1_tick),
    .ratio_o ()
  );

  pcgdu_prescaler u_bus2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (st.bus2_clk_ratio),
    .tick_o  (bus2_tick),
    .ratio_o ()
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0;
    if (wr_i) begin
      case (addr_i)
        `PCGDU_PLL_CFG_OFF:
          next_st.pll_cfg = wdata_i[7:0] & `PCGDU_PLL_CFG_MASK;
        `PCGDU_PERIPH_GATE_OFF:
          next_st.gate = wdata_i[16:0];
        `PCGDU_SYS_MODE_OFF: begin
          if (!wdata_i[`PCGDU_IDLE_BIT]) begin
            next_st.idle_until_irq = 1'b0;
          end
          next_st.soft_req = wdata_i[`PCGDU_SOFT_RST_BIT] & (&st.allow);
        end
        `PCGDU_CLK_CTRL_OFF:
          next_st.allow = wdata_i[1:0];
        `PCGDU_MAIN_PRESC_OFF:
          next_st.main_clk_ratio = wdata_i[1:0];
        `PCGDU_BUS_PRESC_OFF: begin
          next_st.bus1_clk_ratio = wdata_i[1:0];
          next_st.bus2_clk_ratio = wdata_i[`PCGDU_BUS2_LSB +: 2];
        end
        `PCGDU_PERIPH_RST_OFF:
          next_st.prst = wdata_i[3:0] & `PCGDU_PRST_MASK;
        default: begin
        end
      endcase
    end else begin
      next_st.soft_req = 1'b0;
    end
    // Ack wins over a same-cycle clear so no wake is lost
    if (irq_ack_i) begin
      next_st.idle_until_irq = 1'b1;
    end
    if (rd_i) begin
      case (addr_i)
        `PCGDU_PLL_CFG_OFF:     next_st.rdata = {24'h0, st.pll_cfg};
        `PCGDU_PERIPH_GATE_OFF: next_st.rdata = {15'h0, st.gate};
        `PCGDU_SYS_MODE_OFF:    next_st.rdata = {30'h0, 1'b0, st.idle_until_irq};
        `PCGDU_CLK_CTRL_OFF:    next_st.rdata = {30'h0, st.allow};
        `PCGDU_MAIN_PRESC_OFF:  next_st.rdata = {30'h0, st.main_clk_ratio};
        `PCGDU_BUS_PRESC_OFF:
          next_st.rdata = {22'h0, st.bus2_clk_ratio, 6'h0, st.bus1_clk_ratio};
        `PCGDU_PERIPH_RST_OFF:  next_st.rdata = {28'h0, st.prst};
        default:                next_st.rdata = 32'h0;
      endcase
    end
    // Memory interface reset moves only on a main clock tick
    if (main_tick) begin
      next_st.extmem_rst = st.prst[`PCGDU_EXTMEM_RST_BIT];
    end
    // PLL control: bypass stops PLL unless free-run keeps it going
    next_st.mult = mult_of(st.pll_cfg[`PCGDU_MULT_LSB +: 2]);
    next_st.pll_en = !pll_bypassed(st.pll_cfg) || st.pll_cfg[`PCGDU_FREE_RUN_BIT];
    if (pll_bypassed(st.pll_cfg) && !st.pll_cfg[`PCGDU_FREE_RUN_BIT]) begin
      next_st.path_sel = 1'b0;
    end else if (st.pll_cfg[`PCGDU_FREE_RUN_BIT]) begin
      next_st.path_sel = path_request_i;
    end else begin
      next_st.path_sel = path_request_i && pll_lock_i && regulator_good_i;
    end
    case (st.mode)
      pcgdu_pkg::PCGDU_RUN: begin
        if (st.soft_req) begin
          next_st.mode = pcgdu_pkg::PCGDU_SOFT_RESET;
        end else if (!next_st.idle_until_irq) begin
          next_st.mode = pcgdu_pkg::PCGDU_IDLE;
        end
      end
      pcgdu_pkg::PCGDU_IDLE: begin
        if (next_st.idle_until_irq) begin
          next_st.mode = pcgdu_pkg::PCGDU_RUN;
        end
      end
      pcgdu_pkg::PCGDU_SOFT_RESET: next_st.mode = pcgdu_pkg::PCGDU_SOFT_RESET;
      default: next_st.mode = pcgdu_pkg::PCGDU_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                <= '0;
      st.pll_cfg        <= `PCGDU_PLL_CFG_RST;
      st.gate           <= `PCGDU_PERIPH_GATE_RST;
      st.idle_until_irq <= 1'b1;
      st.mult           <= 5'd20;
      st.mode           <= pcgdu_pkg::PCGDU_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [16:0] gate_q;
  logic        main_en_q;
  logic        bus1_en_q;
  logic        bus2_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q    <= 17'h0;
      main_en_q <= 1'b0;
      bus1_en_q <= 1'b0;
      bus2_en_q <= 1'b0;
    end else begin
      gate_q    <= st.gate & {17{main_tick}};
      main_en_q <= main_tick;
      bus1_en_q <= bus1_tick;
      bus2_en_q <= bus2_tick;
    end
  end

  assign rdata_o           = st.rdata;
  assign pll_enable_o      = st.pll_en;
  assign pll_free_run_o    = st.pll_cfg[`PCGDU_FREE_RUN_BIT];
  assign ref_input_band_o  = st.pll_cfg[`PCGDU_REF_BAND_BIT];
  assign pll_multiplier_o  = st.mult;
  assign pll_divisor_o     = st.pll_cfg[`PCGDU_DIV_MSB:0];
  assign pll_path_select_o = st.path_sel;
  assign periph_clk_gate_o = gate_q;
  assign extmem_clk_en_o   = gate_q[`PCGDU_GATE_EXTMEM_BIT];
  assign usb_clk_en_o      = gate_q[`PCGDU_GATE_USB_BIT];
  assign cpu_idle_o        = (st.mode == pcgdu_pkg::PCGDU_IDLE);
  assign soft_reset_o      = (st.mode == pcgdu_pkg::PCGDU_SOFT_RESET);
  assign main_clk_en_o     = main_en_q;
  assign bus1_clk_en_o     = bus1_en_q;
  assign bus2_clk_en_o     = bus2_en_q;
  assign extmem_if_reset_o = st.extmem_rst;

  // ****************************************
  // Checks
  // ****************************************
  path_low_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_bypassed(st.pll_cfg) && !st.pll_cfg[7]) |=> !st.path_sel)
    else $error("path select set while pll bypassed");

  path_needs_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.pll_cfg[7] && !(pll_lock_i && regulator_good_i)) |=> !st.path_sel)
    else $error("path select without lock");

  free_run_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.pll_cfg[7] && path_request_i) |=> (st.path_sel && st.pll_en))
    else $error("free run did not select pll");

  pll_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_bypassed(st.pll_cfg) && !st.pll_cfg[7]) |=> !st.pll_en)
    else $error("pll not off in bypass");

  mult_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(st.pll_cfg) |=> (st.mult == mult_of($past(st.pll_cfg[5:4]))))
    else $error("multiplier decode wrong");

  pll_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(rd_i) && $past(addr_i) == 8'h18) |-> (rdata_o[31:8] == 24'h0 && !rdata_o[3]))
    else $error("pll reserved bits nonzero");

  soft_reset_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == 8'h20 && wdata_i[1] && !(&st.allow)) |=> !st.soft_req)
    else $error("soft reset without permission");

  wake_on_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.idle_until_irq && irq_ack_i) |=> st.idle_until_irq ##1 !cpu_idle_o)
    else $error("wait bit not restored by ack");

  main_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (main_tick && main_eff == 2'h1) |=> !main_tick ##1 main_tick)
    else $error("main divide by two wrong");

  extmem_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(st.extmem_rst) |-> $past(main_tick))
    else $error("memory reset changed off main tick");
endmodule

// ### verif/pcgdu_top_tb.sv
`timescale 1ns/1ps
module pcgdu_top_tb;
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        pll_lock_i;
  logic        regulator_good_i;
  logic        path_request_i;
  logic        irq_ack_i;
  logic        pll_enable_o;
  logic        pll_free_run_o;
  logic        ref_input_band_o;
  logic [4:0]  pll_multiplier_o;
  logic [2:0]  pll_divisor_o;
  logic        pll_path_select_o;
  logic [16:0] periph_clk_gate_o;
  logic        extmem_clk_en_o;
  logic        usb_clk_en_o;
  logic        cpu_idle_o;
  logic        soft_reset_o;
  logic        main_clk_en_o;
  logic        bus1_clk_en_o;
  logic        bus2_clk_en_o;
  logic        extmem_if_reset_o;
  logic [5:0]  mon;
  logic [4:0]  mt [4];
  int          n_mismatch;
  int          compares;
  int          cyc;

  assign mon = {bus2_clk_en_o, bus1_clk_en_o, main_clk_en_o, usb_clk_en_o, extmem_clk_en_o,
                periph_clk_gate_o[0]};

  pcgdu_top i_dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .addr_i            (addr_i),
    .wdata_i           (wdata_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rdata_o           (rdata_o),
    .pll_lock_i        (pll_lock_i),
    .regulator_good_i  (regulator_good_i),
    .path_request_i    (path_request_i),
    .irq_ack_i         (irq_ack_i),
    .pll_enable_o      (pll_enable_o),
    .pll_free_run_o    (pll_free_run_o),
    .ref_input_band_o  (ref_input_band_o),
    .pll_multiplier_o  (pll_multiplier_o),
    .pll_divisor_o     (pll_divisor_o),
    .pll_path_select_o (pll_path_select_o),
    .periph_clk_gate_o (periph_clk_gate_o),
    .extmem_clk_en_o   (extmem_clk_en_o),
    .usb_clk_en_o      (usb_clk_en_o),
    .cpu_idle_o        (cpu_idle_o),
    .soft_reset_o      (soft_reset_o),
    .main_clk_en_o     (main_clk_en_o),
    .bus1_clk_en_o     (bus1_clk_en_o),
    .bus2_clk_en_o     (bus2_clk_en_o),
    .extmem_if_reset_o (extmem_if_reset_o)
  );

  // ****************************************
  // Clock, timeout, verdict
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 820 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic cnt(input int sel, input int n, input logic [31:0] exp);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (mon[sel] === 1'b1) c++;
    end
    chk(c, exp);
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pll_lock_i = 1'b1;
    regulator_good_i = 1'b1;
    path_request_i = 1'b1;
    irq_ack_i = 1'b0;
    mt = '{5'h14, 5'h0c, 5'h18, 5'h10};
    do_reset();
    rchk(8'h18, 32'h7);
    rchk(8'h1c, 32'h1ffff);
    rchk(8'h20, 32'h1);
    rchk(8'h40, 32'h0);
    rchk(8'h44, 32'h0);
    rchk(8'h48, 32'h0);
    rchk(8'h30, 32'h0);
    chk(pll_enable_o, 32'h0);
    chk(pll_divisor_o, 32'h7);
    chk(pll_path_select_o, 32'h0);
    cnt(0, 8, 8);
    // PLL settings, free-run first with lock missing
    pll_lock_i <= 1'b0;
    wr(8'h18, 32'hffffffff);
    rchk(8'h18, 32'hf7);
    chk(pll_free_run_o, 32'h1);
    chk(ref_input_band_o, 32'h1);
    chk(pll_enable_o, 32'h1);
    chk(pll_path_select_o, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, 32'h7);
      wr(8'h18, 32'(i << 4));
      wait_n(2);
      chk(pll_multiplier_o, mt[i]);
      chk(ref_input_band_o, 32'h0);
      chk(pll_free_run_o, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      wr(8'h18, 32'h40 | 32'(i));
      wait_n(2);
      chk(pll_divisor_o, 32'(i));
      chk(pll_enable_o, 32'h1);
      chk(pll_path_select_o, 32'h0);
    end
    pll_lock_i <= 1'b1;
    wait_n(3);
    chk(pll_path_select_o, 32'h1);
    path_request_i <= 1'b0;
    wait_n(3);
    chk(pll_path_select_o, 32'h0);
    path_request_i <= 1'b1;
    wait_n(3);
    chk(pll_path_select_o, 32'h1);
    regulator_good_i <= 1'b0;
    wait_n(3);
    chk(pll_path_select_o, 32'h0);
    regulator_good_i <= 1'b1;
    wr(8'h18, 32'h7);
    wait_n(3);
    chk(pll_enable_o, 32'h0);
    chk(pll_path_select_o, 32'h0);
    // Gates: only memory interface and USB left running
    wr(8'h1c, 32'h14);
    rchk(8'h1c, 32'h14);
    cnt(1, 8, 8);
    cnt(2, 8, 8);
    cnt(0, 8, 0);
    chk(periph_clk_gate_o[16:5], 32'h0);
    wr(8'h1c, 32'hffffffff);
    rchk(8'h1c, 32'h1ffff);
    // Prescalers, bus clocks first at the main ratio, then slower than main (nothing stops a faster bus setting)
    for (int r = 0; r < 4; r++) begin
      wr(8'h40, 32'(r));
      wr(8'h44, 32'(r | (r << 8)));
      rchk(8'h40, 32'(r));
      wait_n(16);
      cnt(3, 32, 32 >> r);
      cnt(4, 32, 32 >> r);
      cnt(5, 32, 32 >> r);
    end
    wr(8'h40, 32'hffffffff);
    rchk(8'h40, 32'h3);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'hffffffff);
    rchk(8'h44, 32'h303);
    wr(8'h44, 32'h301);
    wait_n(16);
    cnt(3, 32, 32);
    cnt(4, 32, 16);
    cnt(5, 32, 4);
    // Memory interface reset and factory bits
    wr(8'h48, 32'hffffffff);
    rchk(8'h48, 32'hf);
    wait_n(2);
    chk(extmem_if_reset_o, 32'h1);
    wr(8'h48, 32'h0);
    wait_n(3);
    chk(extmem_if_reset_o, 32'h0);
    // Wait for interrupt
    wr(8'h20, 32'h1);
    wait_n(2);
    chk(cpu_idle_o, 32'h0);
    wr(8'h20, 32'h0);
    wait_n(1);
    chk(cpu_idle_o, 32'h1);
    wr(8'h20, 32'h1);
    rchk(8'h20, 32'h0);
    @(posedge clk_i);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    wait_n(2);
    chk(cpu_idle_o, 32'h0);
    rchk(8'h20, 32'h1);
    // Software reset needs both permission bits
    wr(8'h20, 32'h3);
    wait_n(4);
    chk(soft_reset_o, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h3);
    wait_n(4);
    chk(soft_reset_o, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h20, 32'h3);
    wait_n(4);
    chk(soft_reset_o, 32'h0);
    wr(8'h00, 32'h3);
    wr(8'h20, 32'h1);
    wait_n(4);
    chk(soft_reset_o, 32'h0);
    wr(8'h20, 32'h3);
    wait_n(2);
    chk(soft_reset_o, 32'h1);
    do_reset();
    wait_n(1);
    chk(soft_reset_o, 32'h0);
    rchk(8'h20, 32'h1);
    end_sim();
  end
endmodule
